// file: design/gpc_pkg.sv
// Constants shared by the pin configuration block of GPIO group five.
package gpc_pkg;
  // Number of pins in the group.
  localparam int GPC_PINS = 8;
  // Width of the APB byte address.
  localparam int GPC_AW = 12;
  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0] GPC_CFG_IDX [GPC_PINS] = '{8'h3f, 8'h40, 8'h41, 8'h42,
                                                    8'h43, 8'h44, 8'h45, 8'h46};
  // Index of the pin level register.
  localparam logic [7:0] GPC_LEVEL_IDX = 8'h50;
  // Reset values of the configuration registers, pin 0 first.
  localparam logic [7:0] GPC_CFG_RST [GPC_PINS] = '{8'h01, 8'h01, 8'h01, 8'h00,
                                                    8'h01, 8'h01, 8'h01, 8'h01};
  // Field positions inside a configuration register.
  localparam int GPC_DIR_BIT = 0;
  localparam int GPC_INV_BIT = 1;
  localparam int GPC_SEL_LO = 2;
  localparam int GPC_SEL_HI = 3;
  localparam int GPC_OD_BIT = 7;
  // Writable bits for pins with a one-bit and a two-bit select.
  localparam logic [7:0] GPC_MASK_NARROW = 8'h87;
  localparam logic [7:0] GPC_MASK_WIDE = 8'h8f;
  // Pins 2 and 3 carry the two-bit select.
  localparam logic [GPC_PINS-1:0] GPC_WIDE_PINS = 8'h0c;
  // Function select codes.
  typedef enum logic [1:0] {GPC_SEL_GPIO, GPC_SEL_PORT2, GPC_SEL_IR, GPC_SEL_RSVD} gpc_sel_t;
endpackage

// file: design/gpc_pin_config.sv
// APB register file and pin multiplexer for the eight pins of GPIO group five.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

// How it works
// - Bit 0 high makes input, low output
// - Bit 1 high inverts pin value
// - Bit 7 high gives open drain output
// - Bit 2 routes serial port two modem lines
// - Bits 3:2 pick GPIO, port two, infrared
module gpc_pin_config
  import gpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GPC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [GPC_PINS-1:0] pin_in,
  output logic [GPC_PINS-1:0] pin_out,
  output logic [GPC_PINS-1:0] pin_oe,
  input wire logic [GPC_PINS-1:0] gpio_out,
  output logic [GPC_PINS-1:0] gpio_in,
  input wire logic port2_transmit_data,
  input wire logic infrared_transmit,
  input wire logic port2_request_to_send_n,
  input wire logic port2_terminal_ready_n,
  output logic port2_ring_indicator_n,
  output logic port2_carrier_detect_n,
  output logic port2_receive_data,
  output logic infrared_receive,
  output logic port2_data_set_ready_n,
  output logic port2_clear_to_send_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Maps a byte address to {hit, pin}; used by both read and write paths.
  function automatic logic [3:0] gpc_decode(input logic [GPC_AW-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < GPC_PINS; k++)
    begin
      if (a == {2'b00, GPC_CFG_IDX[k], 2'b00})
      begin
        r = {1'b1, 3'(k)};
      end
    end
    return r;
  endfunction

  // Returns the function select of a pin; one-bit pins never reach the infrared code.
  function automatic gpc_sel_t gpc_select(input int p, input logic [7:0] c);
    if (GPC_WIDE_PINS[p])
    begin
      return gpc_sel_t'(c[GPC_SEL_HI:GPC_SEL_LO]);
    end
    return gpc_sel_t'({1'b0, c[GPC_SEL_LO]});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and bus decode.

  logic [7:0] cfg_r [GPC_PINS]; // Configuration registers, masked on write.
  logic [3:0] dec; // Decoded configuration hit and pin.
  logic level_hit; // Address of the pin level register.
  logic wr_en; // Write to a configuration register in the access phase.
  logic [31:0] rd_nxt; // Read data for the current address.
  logic [31:0] prdata_r; // Read data captured in the setup phase.
  logic pslverr_r; // Error flag captured in the setup phase.
  logic [GPC_PINS-1:0] lvl; // Pin levels after polarity.
  logic [GPC_PINS-1:0] val; // Value to drive, after polarity.
  logic [GPC_PINS-1:0] out_nxt; // Next pin data.
  logic [GPC_PINS-1:0] oe_nxt; // Next pin enable.
  logic [GPC_PINS-1:0] pin_out_r; // Registered pin data.
  logic [GPC_PINS-1:0] pin_oe_r; // Registered pin enable.
  logic [GPC_PINS-1:0] gpio_in_r; // Registered levels towards the GPIO user.
  logic [5:0] alt_r; // Registered alternate inputs towards serial port two and infrared receive.

  assign dec = gpc_decode(paddr);
  assign level_hit = (paddr == {2'b00, GPC_LEVEL_IDX, 2'b00});
  // Only the low byte lane carries register data, so pstrb[0] gates the write.
  assign wr_en = psel && penable && pwrite && pstrb[0] && dec[3];

  // Read mux; the level register shows the block's own view of the pins.
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (dec[3])
    begin
      rd_nxt = {24'h00_0000, cfg_r[dec[2:0]]};
    end
    else if (level_hit)
    begin
      rd_nxt = {24'h00_0000, gpio_in_r};
    end
  end

  // Read data is captured in the setup phase so that prdata comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_r <= rd_nxt;
      pslverr_r <= !(dec[3] || (level_hit && !pwrite));
    end
  end

  // The slave never stalls, so every access phase lasts one cycle.
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers and per-pin multiplexing.

  generate
    for (genvar i = 0; i < GPC_PINS; i++)
    begin : g_pin
      localparam logic [7:0] MASK = GPC_WIDE_PINS[i] ? GPC_MASK_WIDE : GPC_MASK_NARROW;
      gpc_sel_t sel; // Function selected for this pin.
      logic src; // Uninverted value that the selected function drives.

      // Masked store: reserved bits never latch, so they always read zero.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cfg_r[i] <= GPC_CFG_RST[i];
        end
        else if (wr_en && dec[2:0] == 3'(i))
        begin
          cfg_r[i] <= pwdata[7:0] & MASK;
        end
      end

      assign sel = gpc_select(i, cfg_r[i]);

      // Only pins 3, 5 and 7 take an output from serial port two.
      if (i == 3)
      begin : g_tx
        // Reserved code 11 falls back to plain GPIO rather than leaving the pin dead.
        assign src = (sel == GPC_SEL_PORT2) ? port2_transmit_data :
                     (sel == GPC_SEL_IR) ? infrared_transmit : gpio_out[i];
      end
      else if (i == 5)
      begin : g_rts
        assign src = (sel == GPC_SEL_PORT2) ? port2_request_to_send_n : gpio_out[i];
      end
      else if (i == 7)
      begin : g_dtr
        assign src = (sel == GPC_SEL_PORT2) ? port2_terminal_ready_n : gpio_out[i];
      end
      else
      begin : g_plain
        assign src = gpio_out[i];
      end

      assign val[i] = src ^ cfg_r[i][GPC_INV_BIT];
      assign lvl[i] = pin_in[i] ^ cfg_r[i][GPC_INV_BIT];
      // Open drain only pulls low; push-pull drives both levels.
      assign oe_nxt[i] = !cfg_r[i][GPC_DIR_BIT] &&
                         (cfg_r[i][GPC_OD_BIT] ? !val[i] : 1'b1);
      assign out_nxt[i] = !cfg_r[i][GPC_OD_BIT] && val[i];

      // Checks skip the edge at which reset lifts, since the outputs still hold reset values.
      // An input pin is never driven.
      a_input_float: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && cfg_r[i][GPC_DIR_BIT] |=> !pin_oe[i])
        else $error("input pin is driven");
      // A push-pull GPIO pin drives the user value after polarity.
      a_push_pull: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && !cfg_r[i][GPC_DIR_BIT] && !cfg_r[i][GPC_OD_BIT] && sel == GPC_SEL_GPIO
        |=> pin_oe[i] && pin_out[i] == $past(gpio_out[i] ^ cfg_r[i][GPC_INV_BIT]))
        else $error("push-pull pin drives wrong value");
      // An open-drain pin never drives high and is released for a one.
      a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && !cfg_r[i][GPC_DIR_BIT] && cfg_r[i][GPC_OD_BIT]
        |=> !pin_out[i] && pin_oe[i] == !$past(val[i]))
        else $error("open-drain pin drives wrong level");
      // The user sees each pin through its polarity bit.
      a_input_invert: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> gpio_in[i] == $past(pin_in[i] ^ cfg_r[i][GPC_INV_BIT]))
        else $error("pin level polarity wrong");
      // Reserved bits stay clear.
      a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[i] & ~MASK) == 8'h00)
        else $error("reserved bit set");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin and user outputs.

  // Pins reset to the input state that every register but pin 3 holds after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out_r <= 8'h00;
      pin_oe_r <= 8'h00;
      gpio_in_r <= 8'h00;
    end
    else
    begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
      gpio_in_r <= lvl;
    end
  end

  // Alternate inputs rest at their idle levels when their pin is plain GPIO,
  // so the serial port never sees a stray modem change.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Infrared receive idles low; every modem line and receive data idle high.
      alt_r <= 6'h37;
    end
    else
    begin
      alt_r[0] <= cfg_r[0][GPC_SEL_LO] ? lvl[0] : 1'b1;
      alt_r[1] <= cfg_r[1][GPC_SEL_LO] ? lvl[1] : 1'b1;
      alt_r[2] <= (gpc_select(2, cfg_r[2]) == GPC_SEL_PORT2) ? lvl[2] : 1'b1;
      alt_r[3] <= (gpc_select(2, cfg_r[2]) == GPC_SEL_IR) ? lvl[2] : 1'b0;
      alt_r[4] <= cfg_r[4][GPC_SEL_LO] ? lvl[4] : 1'b1;
      alt_r[5] <= cfg_r[6][GPC_SEL_LO] ? lvl[6] : 1'b1;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign gpio_in = gpio_in_r;
  assign port2_ring_indicator_n = alt_r[0];
  assign port2_carrier_detect_n = alt_r[1];
  assign port2_receive_data = alt_r[2];
  assign infrared_receive = alt_r[3];
  assign port2_data_set_ready_n = alt_r[4];
  assign port2_clear_to_send_n = alt_r[5];

  ////////////////////////////////////////////////////////////////////////////
  // Checks on routing and register writes.

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_cfg_write;
    psel && penable && pwrite && pstrb[0] && dec[3];
  endsequence

  // Routing checks are held off at the reset release edge, where outputs show reset values.
  // A full write lands in the addressed register with reserved bits dropped.
  a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 s_cfg_write |=> (cfg_r[$past(dec[2:0])] ==
      ($past(pwdata[7:0]) & (GPC_WIDE_PINS[$past(dec[2:0])] ? GPC_MASK_WIDE : GPC_MASK_NARROW))))
    else $error("configuration write not stored");
  // Ring indicator follows pin 0 when routed.
  a_ring_route: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && cfg_r[0][GPC_SEL_LO]
    |=> port2_ring_indicator_n == $past(pin_in[0] ^ cfg_r[0][GPC_INV_BIT]))
    else $error("ring indicator not routed");
  // Ring indicator idles high when pin 0 is plain GPIO.
  a_ring_idle: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !cfg_r[0][GPC_SEL_LO] |=> port2_ring_indicator_n)
    else $error("ring indicator not idle");
  // Request to send reaches pin 5 when routed as push-pull output.
  a_rts_route: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && cfg_r[5][GPC_SEL_LO] && !cfg_r[5][GPC_DIR_BIT] && !cfg_r[5][GPC_OD_BIT]
    |=> pin_out[5] == $past(port2_request_to_send_n ^ cfg_r[5][GPC_INV_BIT]))
    else $error("request to send not routed");
  // Terminal ready reaches pin 7 when routed as push-pull output.
  a_dtr_route: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && cfg_r[7][GPC_SEL_LO] && !cfg_r[7][GPC_DIR_BIT] && !cfg_r[7][GPC_OD_BIT]
    |=> pin_out[7] == $past(port2_terminal_ready_n ^ cfg_r[7][GPC_INV_BIT]))
    else $error("terminal ready not routed");
  // Transmit data reaches pin 3 under code 01.
  a_tx_route: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !cfg_r[3][GPC_DIR_BIT] && !cfg_r[3][GPC_OD_BIT] && cfg_r[3][3:2] == 2'h1
    |=> pin_out[3] == $past(port2_transmit_data ^ cfg_r[3][GPC_INV_BIT]))
    else $error("transmit data not routed");
  // Infrared transmit reaches pin 3 under code 10.
  a_ir_route: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !cfg_r[3][GPC_DIR_BIT] && !cfg_r[3][GPC_OD_BIT] && cfg_r[3][3:2] == 2'h2
    |=> pin_out[3] == $past(infrared_transmit ^ cfg_r[3][GPC_INV_BIT]))
    else $error("infrared transmit not routed");
  // Receive goes to infrared only under code 10.
  a_rx_split: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && cfg_r[2][3:2] == 2'h2
    |=> port2_receive_data && infrared_receive == $past(lvl[2]))
    else $error("infrared receive not routed");

endmodule

// file: tb/gpc_pin_config_tb.sv
// Self-checking bench for the group five pin configuration block.
`timescale 1ns/1ps
module gpc_pin_config_tb
  import gpc_pkg::*;
;
  // Mode table for the plain GPIO sweep: out, inverted, open drain, inputs.
  localparam logic [7:0] MODES [6] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h01, 8'h03};
  // Byte address of the pin level register.
  localparam logic [GPC_AW-1:0] LVL = GPC_AW'({GPC_LEVEL_IDX, 2'b00});
  // Every input gets a value at time zero.
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [GPC_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er;
  logic [7:0] pin_in = 8'h3c, gpio_out = 8'h5a, pin_out, pin_oe, gpio_in;
  logic port2_transmit_data = 1'b0, infrared_transmit = 1'b0;
  logic port2_request_to_send_n = 1'b0, port2_terminal_ready_n = 1'b0;
  logic port2_ring_indicator_n, port2_carrier_detect_n, port2_receive_data;
  logic infrared_receive, port2_data_set_ready_n, port2_clear_to_send_n;
  int bad_count = 0, tests_run = 0;

  // The 125 MHz clock.
  always #4 pclk = ~pclk;

  gpc_pin_config uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .gpio_out, .gpio_in,
    .port2_transmit_data, .infrared_transmit, .port2_request_to_send_n,
    .port2_terminal_ready_n, .port2_ring_indicator_n, .port2_carrier_detect_n,
    .port2_receive_data, .infrared_receive, .port2_data_set_ready_n, .port2_clear_to_send_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Compare an 8-bit pin result; case inequality so unknowns never match.
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare a full 32-bit read word.
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [GPC_AW-1:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Byte address of a pin's configuration register.
  function automatic logic [GPC_AW-1:0] ca(input int i);
    return GPC_AW'({GPC_CFG_IDX[i], 2'b00});
  endfunction

  // Write a configuration register with the byte lane enabled.
  task automatic cfg(input int i, input logic [7:0] v);
    apb(1'b1, ca(i), v, 4'hf);
  endtask

  // Read a register and check both the data and the error flag.
  task automatic rdchk(input logic [GPC_AW-1:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 8'h00, 4'hf);
    chk_reg(rd, {24'h0, e});
    chk_pin({7'h0, er}, {7'h0, ee});
  endtask

  // Pins follow a cause one edge later; two edges leave margin, #1 lets updates land.
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Put all pins in one plain GPIO mode and check the pads.
  task automatic gpio_mode(input logic [7:0] v);
    logic [7:0] val;
    val = gpio_out ^ {8{v[1]}};
    for (int i = 0; i < 8; i++)
      cfg(i, v);
    settle();
    chk_pin(gpio_in, pin_in ^ {8{v[1]}});
    chk_pin(pin_oe, v[0] ? 8'h00 : (v[7] ? ~val : 8'hff));
    // Pad data only means something while the pin drives.
    if (!v[0])
      chk_pin(pin_out, v[7] ? 8'h00 : val);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Report counts and the verdict, then stop.
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The tests need well under ten thousand cycles, so this limit means a hang.
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [7:0] v, x;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    // After reset only pin 3 is an output, and alternate inputs sit idle.
    // Pad data follows the uninverted push-pull user value on every pin, driven or not.
    chk_pin(pin_oe, 8'h08);
    chk_pin(pin_out, gpio_out);
    chk_pin({port2_ring_indicator_n, port2_carrier_detect_n, port2_receive_data,
      port2_data_set_ready_n, port2_clear_to_send_n, infrared_receive, 2'b00}, 8'hf8);
    for (int i = 0; i < 8; i++)
      rdchk(ca(i), GPC_CFG_RST[i], 1'b0);
    // Reserved bits must drop on write; only pins 2 and 3 keep bit 3.
    for (int i = 0; i < 8; i++)
      cfg(i, 8'hff);
    for (int i = 0; i < 8; i++)
      rdchk(ca(i), GPC_WIDE_PINS[i] ? 8'h8f : 8'h87, 1'b0);
    apb(1'b1, ca(0), 8'h00, 4'h0);
    rdchk(ca(0), 8'h87, 1'b0);
    rdchk(12'h000, 8'h00, 1'b1);
    for (int m = 0; m < 6; m++)
      gpio_mode(MODES[m]);
    rdchk(LVL, ~pin_in, 1'b0);
    apb(1'b1, LVL, 8'hff, 4'hf);
    chk_pin({7'h0, er}, 8'h01);
    // Modem inputs and the receive select, plain and inverted, two pad patterns.
    for (int k = 0; k < 4; k++)
    begin
      v = k[0] ? 8'h07 : 8'h05;
      @(posedge pclk);
      pin_in <= k[1] ? 8'haa : 8'h55;
      for (int i = 0; i < 8; i++)
        cfg(i, v);
      settle();
      x = pin_in ^ {8{k[0]}};
      chk_pin({2'b00, port2_ring_indicator_n, port2_carrier_detect_n, port2_receive_data,
        port2_data_set_ready_n, port2_clear_to_send_n, infrared_receive},
        {2'b00, x[0], x[1], x[2], x[4], x[6], 1'b0});
      cfg(2, v + 8'h04);
      settle();
      chk_pin({6'h0, port2_receive_data, infrared_receive}, {6'h0, 1'b1, x[2]});
    end
    // Modem and transmit outputs driven onto the pads.
    for (int k = 0; k < 2; k++)
    begin
      @(posedge pclk);
      {port2_transmit_data, infrared_transmit, port2_request_to_send_n,
        port2_terminal_ready_n} <= k[0] ? 4'b1010 : 4'b0101;
      v = k[0] ? 8'h06 : 8'h04;
      cfg(3, v);
      cfg(5, v);
      cfg(7, v);
      settle();
      chk_pin(pin_oe & 8'ha8, 8'ha8);
      chk_pin(pin_out & 8'ha8, {port2_terminal_ready_n ^ k[0], 1'b0,
        port2_request_to_send_n ^ k[0], 1'b0, port2_transmit_data ^ k[0], 3'b000});
      cfg(3, v + 8'h04);
      settle();
      chk_pin(pin_out & 8'h08, {4'h0, infrared_transmit ^ k[0], 3'b000});
      // The reserved select falls back to the plain GPIO path.
      cfg(3, v + 8'h08);
      settle();
      chk_pin(pin_out & 8'h08, {4'h0, gpio_out[3] ^ k[0], 3'b000});
    end
    tally_and_finish();
  end
endmodule
